/* core/adq_acquire_ctrl.sv */
`timescale 1ns/10ps
module adq_acquire_ctrl import adq_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [5:0] ioAddr,
  input wire logic ioWr,
  input wire logic ioRd,
  input wire logic [31:0] ioWdata,
  output logic [31:0] ioRdata,
  output logic convStart,
  output logic [3:0] convChannel,
  input wire logic convDone,
  input wire logic [11:0] convData,
  input wire logic extTrig,
  output logic dmaEnable,
  output logic busReq,
  input wire logic busGnt,
  output logic mstValid,
  output logic [31:0] mstAddr,
  output logic [31:0] mstData,
  input wire logic mstAck,
  output logic irqReq
);
  typedef struct packed {
    logic [2:0] mode;
    logic [3:0] startChan;
    logic [3:0] curChan;
    logic sweep;
    logic diffIn;
    logic [15:0] div1;
    logic [15:0] div2;
    logic [31:0] dmaAddr;
    logic [26:0] dmaLeft;
    logic [26:0] queueLeft;
    logic dmaRun;
    logic dmaDone;
    logic irqEn;
    logic convBusy;
    logic convStart;
    logic dataReadyN;
    logic irqLevel;
    logic halfValid;
    logic [15:0] halfWord;
    logic [15:0] result;
    logic [31:0] rdata;
    logic [2:0] extSync;
    logic extLevel;
    logic extPrev;
  } adq_state_t;
  adq_state_t st;
  adq_state_t next_st;

  adq_stream_if bufIf ();
  logic tick1;
  logic pacerTick;
  logic pacerRun;
  logic timerMode;
  logic extMode;
  logic dmaMode;
  logic intMode;
  logic softWr;
  logic chanWr;
  logic resultRd;
  logic trigger;
  logic trigOk;
  logic xferDone;
  logic convTaken;
  logic [15:0] packed16;
  logic [3:0] chanLimited;

  assign timerMode = st.mode == ADQ_MODE_TIMER_INT ||
    st.mode == ADQ_MODE_TIMER_DMA;
  assign extMode = st.mode == ADQ_MODE_EXT_POLL ||
    st.mode == ADQ_MODE_EXT_INT || st.mode == ADQ_MODE_EXT_DMA;
  assign dmaMode = st.mode == ADQ_MODE_TIMER_DMA ||
    st.mode == ADQ_MODE_EXT_DMA;
  assign intMode = st.mode == ADQ_MODE_TIMER_INT ||
    st.mode == ADQ_MODE_EXT_INT;
  assign softWr = ioWr && ioAddr == ADQ_OFF_SOFT;
  assign chanWr = ioWr && ioAddr == ADQ_OFF_CHAN;
  assign resultRd = ioRd && ioAddr == ADQ_OFF_RESULT;

  // Pacer stops with an aborted or finished block
  assign pacerRun = timerMode && (!dmaMode || st.dmaRun);

  adq_pacer_div firstDiv (
    .clk(clk),
    .sys_rst(sys_rst),
    .run(pacerRun),
    .tickIn(1'b1),
    .divisor(st.div1),
    .tickOut(tick1)
  );

  adq_pacer_div secondDiv (
    .clk(clk),
    .sys_rst(sys_rst),
    .run(pacerRun),
    .tickIn(tick1),
    .divisor(st.div2),
    .tickOut(pacerTick)
  );

  adq_pair_buffer pairBuf (
    .clk(clk),
    .sys_rst(sys_rst),
    .s(bufIf.fifo)
  );

  // Triggers that arrive while busy or while the buffer is full are dropped
  assign trigOk = !st.convBusy && (!dmaMode ||
    (st.dmaRun && bufIf.inReady && st.queueLeft != 27'h0));
  always_comb begin
    case (st.mode)
      ADQ_MODE_SOFT_POLL: trigger = softWr;
      ADQ_MODE_TIMER_INT, ADQ_MODE_TIMER_DMA: trigger = pacerTick;
      ADQ_MODE_EXT_POLL, ADQ_MODE_EXT_INT, ADQ_MODE_EXT_DMA:
        trigger = st.extLevel && !st.extPrev;
      default: trigger = 1'b0;
    endcase
  end

  assign packed16 = {convData, st.curChan};
  assign chanLimited = ioWdata[ADQ_CHAN_DIFF_BIT] ?
    (ioWdata[3:0] & ADQ_DIFF_MAX) : ioWdata[3:0];
  assign xferDone = mstValid && mstAck;
  assign convTaken = convDone && st.convBusy;

  // Queue a longword; an odd last result is padded with zero above,
  // but only once no conversion is pending, or a pair would split
  assign bufIf.inValid = dmaMode && st.dmaRun && st.halfValid &&
    (convTaken || (st.queueLeft == 27'h0 && !st.convBusy));
  assign bufIf.inData = convTaken ?
    {packed16, st.halfWord} : {16'h0000, st.halfWord};
  assign bufIf.outReady = xferDone;
  assign bufIf.flush = ioWr && ioAddr == ADQ_OFF_DMACTL &&
    (ioWdata[ADQ_CTL_START] || ioWdata[ADQ_CTL_ABORT]);

  always_comb begin
    next_st = st;
    next_st.convStart = 1'b0;
    next_st.extSync = {st.extSync[1:0], extTrig};
    next_st.extPrev = st.extLevel;
    if (st.extSync[2] == st.extSync[1]) begin
      next_st.extLevel = st.extSync[2];
    end
    if (resultRd) begin
      next_st.dataReadyN = 1'b1;
      next_st.irqLevel = 1'b0;
    end
    if (ioWr) begin
      case (ioAddr)
        ADQ_OFF_MODE: begin
          if (ioWdata[2:0] <= ADQ_MODE_EXT_DMA) begin
            next_st.mode = ioWdata[2:0];
          end
        end
        ADQ_OFF_CHAN: begin
          next_st.diffIn = ioWdata[ADQ_CHAN_DIFF_BIT];
          next_st.startChan = chanLimited;
          next_st.curChan = chanLimited;
        end
        ADQ_OFF_SCAN: next_st.sweep = ioWdata[0];
        ADQ_OFF_DIV1: next_st.div1 = ioWdata[15:0];
        ADQ_OFF_DIV2: next_st.div2 = ioWdata[15:0];
        ADQ_OFF_DMAADDR: next_st.dmaAddr = {ioWdata[31:2], 2'b00};
        ADQ_OFF_DMACNT: begin
          next_st.dmaLeft = ioWdata[26:0];
          next_st.queueLeft = ioWdata[26:0];
        end
        ADQ_OFF_DMACTL: begin
          next_st.irqEn = ioWdata[ADQ_CTL_IRQEN];
          next_st.halfValid = 1'b0;
          if (ioWdata[ADQ_CTL_ABORT]) begin
            next_st.dmaRun = 1'b0;
          end else if (ioWdata[ADQ_CTL_START] && dmaMode &&
              st.dmaLeft != 27'h0 && st.dmaLeft <= ADQ_BYTES_MAX) begin
            next_st.dmaRun = 1'b1;
            next_st.dmaDone = 1'b0;
          end
        end
        default: next_st.mode = st.mode;
      endcase
    end
    if (trigger && trigOk) begin
      next_st.convStart = 1'b1;
      next_st.convBusy = 1'b1;
      if (dmaMode) begin
        next_st.queueLeft = (st.queueLeft > ADQ_BYTES_PER_WORD) ?
          st.queueLeft - ADQ_BYTES_PER_WORD : 27'h0;
      end
    end
    if (convDone && st.convBusy) begin
      next_st.convBusy = 1'b0;
      next_st.result = packed16;
      next_st.dataReadyN = 1'b0;
      if (intMode) begin
        next_st.irqLevel = 1'b1;
      end
      if (!chanWr) begin
        if (st.sweep && st.curChan != 4'h0) begin
          next_st.curChan = st.curChan - 4'h1;
        end else begin
          next_st.curChan = st.startChan;
        end
      end
      if (dmaMode && st.dmaRun && !st.halfValid) begin
        next_st.halfWord = packed16;
        next_st.halfValid = 1'b1;
      end
    end
    if (bufIf.inValid && bufIf.inReady) begin
      next_st.halfValid = 1'b0;
    end
    if (xferDone) begin
      next_st.dmaAddr = st.dmaAddr + 32'h00000004;
      if (st.dmaLeft <= ADQ_BYTES_PER_XFER) begin
        next_st.dmaLeft = 27'h0;
        next_st.dmaRun = 1'b0;
        next_st.dmaDone = 1'b1;
      end else begin
        next_st.dmaLeft = st.dmaLeft - ADQ_BYTES_PER_XFER;
      end
    end
    if (ioRd) begin
      case (ioAddr)
        ADQ_OFF_MODE: next_st.rdata = {29'h0, st.mode};
        ADQ_OFF_CHAN: next_st.rdata = {27'h0, st.diffIn, st.startChan};
        ADQ_OFF_SCAN: next_st.rdata = {31'h0, st.sweep};
        ADQ_OFF_RESULT: next_st.rdata = {16'h0000, st.result};
        ADQ_OFF_DIV1: next_st.rdata = {16'h0000, st.div1};
        ADQ_OFF_DIV2: next_st.rdata = {16'h0000, st.div2};
        ADQ_OFF_DMAADDR: next_st.rdata = st.dmaAddr;
        ADQ_OFF_DMACNT: next_st.rdata = {5'h00, st.dmaLeft};
        ADQ_OFF_DMACTL: next_st.rdata = {29'h0, st.irqEn, 2'b00};
        ADQ_OFF_STATUS: next_st.rdata = {27'h0, st.convBusy, irqReq,
          st.dmaDone, st.dmaRun, st.dataReadyN};
        default: next_st.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
      st.mode <= ADQ_MODE_RST;
      st.startChan <= ADQ_CHAN_RST;
      st.curChan <= ADQ_CHAN_RST;
      st.div1 <= ADQ_DIV_RST;
      st.div2 <= ADQ_DIV_RST;
      st.dataReadyN <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Bus is held only while a longword waits
  assign busReq = dmaMode && st.dmaRun && bufIf.outValid;
  assign mstValid = busReq && busGnt;
  assign mstAddr = st.dmaAddr;
  assign mstData = bufIf.outData;
  assign dmaEnable = dmaMode;
  assign irqReq = st.irqLevel || (st.dmaDone && st.irqEn);
  assign convStart = st.convStart;
  assign convChannel = st.curChan;
  assign ioRdata = st.rdata;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_done_sweep;
    convTaken && st.sweep && !chanWr;
  endsequence
  sequence s_done_fixed;
    convTaken && !st.sweep && !chanWr;
  endsequence
  sequence s_soft_go;
    softWr && st.mode == ADQ_MODE_SOFT_POLL && !st.convBusy;
  endsequence
  sequence s_one_pulse;
    convStart ##1 !convStart;
  endsequence
  sequence s_last_xfer;
    xferDone && st.dmaLeft <= ADQ_BYTES_PER_XFER;
  endsequence
  sequence s_read_clear;
    resultRd && !ioWr && !convTaken && !xferDone &&
      !(st.dmaDone && st.irqEn);
  endsequence

  // Mode decode and the bus-master gate
  a_mode_range: assert property (st.mode <= ADQ_MODE_EXT_DMA)
    else $error("mode code out of range");
  a_dma_gate: assert property (busReq |-> dmaMode)
    else $error("bus request outside a bus-master mode");

  // Channel sequencing
  a_sweep_step: assert property (s_done_sweep |=>
    st.curChan == (($past(st.curChan) == 4'h0) ? $past(st.startChan) :
    $past(st.curChan) - 4'h1))
    else $error("sweep channel step wrong");
  a_fixed_chan: assert property (s_done_fixed |=>
    st.curChan == st.startChan)
    else $error("channel moved without sweep");
  a_diff_limit: assert property (st.diffIn |->
    st.curChan <= ADQ_DIFF_MAX)
    else $error("differential channel above limit");

  // Conversion start and result
  a_soft_start: assert property (s_soft_go |=> s_one_pulse)
    else $error("software trigger gave no single pulse");
  a_ready_low: assert property (convTaken |=> !st.dataReadyN)
    else $error("ready bit not low after result");
  a_word_pack: assert property (convTaken |=>
    st.result == {$past(convData), $past(convChannel)})
    else $error("result word packed wrong");

  // Block progress
  a_halt_start: assert property (dmaMode && !st.dmaRun |=>
    !convStart)
    else $error("conversion started with no block running");
  a_queue_limit: assert property (dmaMode &&
    st.queueLeft == 27'h0 |=> !convStart)
    else $error("conversion started past the block size");
  a_block_end: assert property (s_last_xfer |=>
    !st.dmaRun && st.dmaDone)
    else $error("block did not end on byte count");
  a_pad_wait: assert property (bufIf.inValid && !convTaken |->
    !st.convBusy)
    else $error("half longword queued with a result pending");
  a_bus_release: assert property (st.dmaRun && !bufIf.outValid |->
    !busReq)
    else $error("bus held with empty buffer");
  a_bus_return: assert property (dmaMode && st.dmaRun &&
    bufIf.outValid |-> busReq)
    else $error("bus not requested with a longword waiting");
  a_pacer_halt: assert property (!pacerRun |=> !pacerTick)
    else $error("pacer ticked while stopped");

  // Interrupt level
  a_int_raise: assert property (intMode && convTaken |=> irqReq)
    else $error("no interrupt after conversion");
  a_int_clear: assert property (s_read_clear |=> !irqReq)
    else $error("interrupt not cleared by result read");
endmodule

/* core/adq_pkg.sv */
package adq_pkg;
  localparam int ADQ_ADDR_W = 6;
  localparam logic [5:0] ADQ_OFF_MODE = 6'h00;
  localparam logic [5:0] ADQ_OFF_CHAN = 6'h04;
  localparam logic [5:0] ADQ_OFF_SCAN = 6'h08;
  localparam logic [5:0] ADQ_OFF_SOFT = 6'h0c;
  localparam logic [5:0] ADQ_OFF_RESULT = 6'h10;
  localparam logic [5:0] ADQ_OFF_DIV1 = 6'h14;
  localparam logic [5:0] ADQ_OFF_DIV2 = 6'h18;
  localparam logic [5:0] ADQ_OFF_DMAADDR = 6'h1c;
  localparam logic [5:0] ADQ_OFF_DMACNT = 6'h20;
  localparam logic [5:0] ADQ_OFF_DMACTL = 6'h24;
  localparam logic [5:0] ADQ_OFF_STATUS = 6'h28;
  localparam logic [2:0] ADQ_MODE_SOFT_POLL = 3'h0;
  localparam logic [2:0] ADQ_MODE_TIMER_INT = 3'h1;
  localparam logic [2:0] ADQ_MODE_TIMER_DMA = 3'h2;
  localparam logic [2:0] ADQ_MODE_EXT_POLL = 3'h3;
  localparam logic [2:0] ADQ_MODE_EXT_INT = 3'h4;
  localparam logic [2:0] ADQ_MODE_EXT_DMA = 3'h5;
  localparam logic [2:0] ADQ_MODE_RST = ADQ_MODE_SOFT_POLL;
  localparam logic [3:0] ADQ_CHAN_RST = 4'h0;
  localparam logic [3:0] ADQ_DIFF_MAX = 4'h7;
  localparam logic [15:0] ADQ_DIV_RST = 16'h0002;
  localparam int ADQ_CHAN_DIFF_BIT = 4;
  localparam int ADQ_CTL_START = 0;
  localparam int ADQ_CTL_ABORT = 1;
  localparam int ADQ_CTL_IRQEN = 2;
  localparam int ADQ_ST_READYN = 0;
  localparam int ADQ_ST_DMARUN = 1;
  localparam int ADQ_ST_DMADONE = 2;
  localparam int ADQ_ST_IRQ = 3;
  localparam int ADQ_ST_BUSY = 4;
  localparam logic [26:0] ADQ_BYTES_PER_XFER = 27'h0000004;
  localparam logic [26:0] ADQ_BYTES_PER_WORD = 27'h0000002;
  localparam logic [26:0] ADQ_BYTES_MAX = 27'h4000000;
  localparam logic [1:0] ADQ_BUF_DEPTH = 2'h2;
endpackage

/* core/adq_stream_if.sv */
`timescale 1ns/10ps
interface adq_stream_if;
  logic inValid;
  logic inReady;
  logic [31:0] inData;
  logic outValid;
  logic outReady;
  logic [31:0] outData;
  logic flush;
  modport src (output inValid, output inData, output outReady,
    output flush, input inReady, input outValid, input outData);
  modport fifo (input inValid, input inData, input outReady,
    input flush, output inReady, output outValid, output outData);
endinterface

/* core/adq_pacer_div.sv */
`timescale 1ns/10ps
module adq_pacer_div import adq_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic tickIn,
  input wire logic [15:0] divisor,
  output logic tickOut
);
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } adq_div_t;
  adq_div_t st;
  adq_div_t next_st;

  // Divisor 0 or 1 passes every input tick
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (!run) begin
      next_st.cnt = 16'h0000;
    end else if (tickIn) begin
      if ({1'b0, st.cnt} + 17'h00001 >= {1'b0, divisor}) begin
        next_st.cnt = 16'h0000;
        next_st.tick = 1'b1;
      end else begin
        next_st.cnt = st.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tickOut = st.tick;
endmodule

/* core/adq_pair_buffer.sv */
`timescale 1ns/10ps
module adq_pair_buffer import adq_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  adq_stream_if.fifo s
);
  typedef struct packed {
    logic [1:0][31:0] ent;
    logic [1:0] count;
  } adq_buf_t;
  adq_buf_t st;
  adq_buf_t next_st;
  logic push;
  logic pop;

  assign s.inReady = st.count != ADQ_BUF_DEPTH;
  assign s.outValid = st.count != 2'h0;
  assign s.outData = st.ent[0];
  assign push = s.inValid && s.inReady;
  assign pop = s.outValid && s.outReady;

  always_comb begin
    next_st = st;
    if (s.flush) begin
      next_st.count = 2'h0;
    end else begin
      case ({push, pop})
        2'b10: begin
          next_st.ent[st.count[0]] = s.inData;
          next_st.count = st.count + 2'h1;
        end
        2'b01: begin
          next_st.ent[0] = st.ent[1];
          next_st.count = st.count - 2'h1;
        end
        2'b11: begin
          if (st.count == 2'h1) begin
            next_st.ent[0] = s.inData;
          end else begin
            next_st.ent[0] = st.ent[1];
            next_st.ent[1] = s.inData;
          end
        end
        default: begin
          next_st.count = st.count;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

/* sim/adq_far_model.sv */
`timescale 1ns/10ps
module adq_far_model (
  input wire logic clk,
  input wire logic slow,
  input wire logic convStart,
  input wire logic [3:0] convChannel,
  output logic convDone,
  output logic [11:0] convData,
  input wire logic busReq,
  input wire logic mstValid,
  input wire logic [31:0] mstAddr,
  input wire logic [31:0] mstData,
  output logic busGnt,
  output logic mstAck
);
  logic [31:0] mem [logic [31:0]];
  int starts = 0;
  int releases = 0;
  logic prevReq = 1'b0;
  logic phase = 1'b0;
  logic [3:0] ch;
  initial begin
    convDone = 1'b0;
    convData = 12'h000;
    busGnt = 1'b0;
    mstAck = 1'b0;
  end
  // Converter: fixed latency, data line shows garbage outside the strobe
  initial forever begin
    @(posedge clk);
    if (convStart === 1'b1) begin
      starts++;
      ch = convChannel;
      repeat (3) @(posedge clk);
      #1 convDone = 1'b1;
      convData = {ch, 8'h5a};
      @(posedge clk);
      #1 convDone = 1'b0;
      convData = ~convData;
    end
  end
  // Host memory side: grant in the same cycle as the request, ack every other cycle when slow
  initial forever begin
    @(posedge clk);
    if (mstValid === 1'b1 && mstAck === 1'b1) begin
      mem[mstAddr] = mstData;
    end
    if (prevReq === 1'b1 && busReq !== 1'b1) begin
      releases++;
    end
    prevReq = busReq;
    #1 busGnt = busReq;
    mstAck = busReq && busGnt && (!slow || phase);
    phase = ~phase;
  end
endmodule

/* sim/adq_acquire_dma_control_bench.sv */
`timescale 1ns/10ps
module adq_acquire_dma_control_bench;
  import adq_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [5:0] ioAddr = 6'h00;
  logic ioWr = 1'b0;
  logic ioRd = 1'b0;
  logic extTrig = 1'b0;
  logic slow = 1'b0;
  logic [31:0] ioWdata = 32'h0;
  logic [31:0] ioRdata, mstAddr, mstData, rd;
  logic convStart, convDone, dmaEnable, busReq, busGnt, mstValid;
  logic mstAck, irqReq;
  logic [3:0] convChannel;
  logic [11:0] convData;
  int failCount = 0;
  int comparisons = 0;
  int cycles = 0;
  int n0;

  adq_acquire_ctrl dut (.clk(clk), .sys_rst(sys_rst), .ioAddr(ioAddr),
    .ioWr(ioWr), .ioRd(ioRd), .ioWdata(ioWdata), .ioRdata(ioRdata),
    .convStart(convStart), .convChannel(convChannel),
    .convDone(convDone), .convData(convData), .extTrig(extTrig),
    .dmaEnable(dmaEnable), .busReq(busReq), .busGnt(busGnt),
    .mstValid(mstValid), .mstAddr(mstAddr), .mstData(mstData),
    .mstAck(mstAck), .irqReq(irqReq));
  adq_far_model far (.clk(clk), .slow(slow), .convStart(convStart),
    .convChannel(convChannel), .convDone(convDone), .convData(convData),
    .busReq(busReq), .mstValid(mstValid), .mstAddr(mstAddr),
    .mstData(mstData), .busGnt(busGnt), .mstAck(mstAck));

  initial forever #4 clk = ~clk;

  task finishTest;
    $display("comparisons %0d errors %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Limit sized well above the several hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      failCount++;
      $display("ERROR %0t run did not finish", $time);
      finishTest;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      failCount++;
      $display("ERROR %0t %s: got %h expected %h", $time, m, got, exp);
    end
  endtask
  task wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    #1 ioAddr = a;
    ioWdata = d;
    ioWr = 1'b1;
    @(posedge clk);
    #1 ioWr = 1'b0;
  endtask
  task rdr(input logic [5:0] a, output logic [31:0] d);
    @(posedge clk);
    #1 ioAddr = a;
    ioRd = 1'b1;
    @(posedge clk);
    #1 ioRd = 1'b0;
    d = ioRdata;
  endtask
  task wait_st(input int b, input logic lvl);
    for (int i = 0; i < 300; i++) begin
      rdr(ADQ_OFF_STATUS, rd);
      if (rd[b] === lvl) break;
    end
    chk(32'(rd[b]), 32'(lvl), "status bit wait");
  endtask
  function automatic logic [15:0] res(input logic [3:0] c);
    return {c, 8'h5a, c};
  endfunction
  task soft_one(input logic [3:0] c);
    wr(ADQ_OFF_SOFT, 32'h1);
    wait_st(ADQ_ST_READYN, 1'b0);
    rdr(ADQ_OFF_RESULT, rd);
    chk(rd, {16'h0, res(c)}, "result word");
  endtask
  task ext_pulse;
    @(posedge clk);
    #1 extTrig = 1'b1;
    repeat (4) @(posedge clk);
    #1 extTrig = 1'b0;
    repeat (10) @(posedge clk);
  endtask

  task test_reset;
    rdr(ADQ_OFF_MODE, rd);
    chk(rd, 32'h0, "reset mode");
    rdr(ADQ_OFF_CHAN, rd);
    chk(rd, 32'h0, "reset channel");
    chk(32'(convChannel), 32'h0, "reset channel pins");
    rdr(ADQ_OFF_STATUS, rd);
    chk(32'(rd[ADQ_ST_READYN]), 32'h1, "reset ready flag");
    chk(32'(dmaEnable), 32'h0, "reset dma enable");
    rdr(6'h3c, rd);
    chk(rd, 32'h0, "unmapped read");
  endtask
  task test_single;
    wr(ADQ_OFF_CHAN, 32'h5);
    soft_one(4'h5);
    soft_one(4'h5);
    chk(32'(convChannel), 32'h5, "fixed channel");
    // Differential with 12 asked: only the low three bits survive
    wr(ADQ_OFF_CHAN, 32'h1c);
    soft_one(4'h4);
  endtask
  task test_sweep;
    logic [3:0] seq [5] = '{4'h2, 4'h1, 4'h0, 4'h2, 4'h1};
    wr(ADQ_OFF_CHAN, 32'h2);
    wr(ADQ_OFF_SCAN, 32'h1);
    foreach (seq[i]) soft_one(seq[i]);
    wr(ADQ_OFF_SCAN, 32'h0);
  endtask
  task test_modes;
    logic [31:0] e;
    for (int m = 0; m < 8; m++) begin
      wr(ADQ_OFF_MODE, 32'(m));
      e = (m <= 5) ? 32'(m) : 32'h5;
      rdr(ADQ_OFF_MODE, rd);
      chk(rd, e, "mode readback");
      chk(32'(dmaEnable), 32'(e == 2 || e == 5), "dma enable");
    end
  endtask
  task test_irq;
    wr(ADQ_OFF_CHAN, 32'h1);
    wr(ADQ_OFF_MODE, 32'(ADQ_MODE_EXT_INT));
    ext_pulse;
    chk(32'(irqReq), 32'h1, "request after result");
    chk(32'(busReq), 32'h0, "no bus outside dma");
    rdr(ADQ_OFF_RESULT, rd);
    chk(rd, {16'h0, res(4'h1)}, "external result");
    chk(32'(irqReq), 32'h0, "request cleared by read");
  endtask
  task test_dma;
    slow = 1'b1;
    wr(ADQ_OFF_MODE, 32'(ADQ_MODE_EXT_DMA));
    wr(ADQ_OFF_CHAN, 32'h3);
    wr(ADQ_OFF_SCAN, 32'h1);
    wr(ADQ_OFF_DMAADDR, 32'h1000);
    wr(ADQ_OFF_DMACNT, 32'd12);
    wr(ADQ_OFF_DMACTL, 32'h5);
    n0 = far.releases;
    repeat (9) ext_pulse;
    wait_st(ADQ_ST_DMADONE, 1'b1);
    for (int k = 0; k < 3; k++) begin
      chk(far.mem[32'h1000 + 4 * k], {res(4'(3 - (2 * k + 1) % 4)),
        res(4'(3 - (2 * k) % 4))}, "longword");
    end
    chk(32'(far.mem.exists(32'h100c)), 32'h0, "no overrun");
    rdr(ADQ_OFF_DMACNT, rd);
    chk(rd, 32'h0, "bytes left");
    rdr(ADQ_OFF_STATUS, rd);
    chk(32'(rd[ADQ_ST_DMARUN]), 32'h0, "run flag after block");
    chk(32'(irqReq), 32'h1, "completion request");
    chk(32'(far.releases - n0 >= 3), 32'h1, "bus released");
    wr(ADQ_OFF_SCAN, 32'h0);
  endtask
  task test_abort;
    slow = 1'b0;
    wr(ADQ_OFF_MODE, 32'(ADQ_MODE_TIMER_DMA));
    wr(ADQ_OFF_DIV1, 32'h2);
    wr(ADQ_OFF_DIV2, 32'h3);
    wr(ADQ_OFF_DMACNT, 32'd256);
    wr(ADQ_OFF_DMACTL, 32'h1);
    n0 = far.starts;
    repeat (120) @(posedge clk);
    // One tick every six cycles gives about twenty conversions
    n0 = far.starts - n0;
    chk(32'(n0 >= 18 && n0 <= 21), 32'h1, "pacer rate");
    wr(ADQ_OFF_DMACTL, 32'h2);
    repeat (10) @(posedge clk);
    n0 = far.starts;
    repeat (40) @(posedge clk);
    chk(32'(far.starts - n0), 32'h0, "no start after abort");
    rdr(ADQ_OFF_STATUS, rd);
    chk(32'(rd[ADQ_ST_DMARUN]), 32'h0, "run flag after abort");
    chk(32'(busReq), 32'h0, "bus idle after abort");
  endtask

  initial begin
    repeat (8) @(posedge clk);
    #1 sys_rst = 1'b0;
    test_reset;
    test_single;
    test_sweep;
    test_modes;
    test_irq;
    test_dma;
    test_abort;
    finishTest;
  end
endmodule
